// File: core/pvm_motion_block.sv
// Touch-probe and velocity motion block with next-block selection.
// Assumes position, speed and sequencer inputs share clk; probe pin does not.
`include "pvm_params.svh"

module pvm_motion_block #(
   parameter int POS_W   = 32,
   parameter int IDX_W   = 6,
   parameter int SPD_TOL = 16
) (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    resetn,
   // Block sequencer
   input  wire logic                    blk_start,
   input  wire logic [4:0]              blk_mode,
   input  wire logic signed [POS_W-1:0] blk_distance,
   input  wire logic signed [POS_W-1:0] blk_speed,
   input  wire logic [POS_W-2:0]        window_len,
   input  wire logic [6:0]              miss_action,
   input  wire logic                    jog_done,
   input  wire logic                    err_ack,
   // Next-block sources and digital output functions
   input  wire logic [31:0]             delay_cycles,
   input  wire logic [IDX_W-1:0]        delay_next,
   input  wire logic                    event1,
   input  wire logic [IDX_W-1:0]        event1_next,
   input  wire logic                    event2,
   input  wire logic [IDX_W-1:0]        event2_next,
   input  wire logic                    int_event1,
   input  wire logic [IDX_W-1:0]        int1_next,
   input  wire logic                    int_event2,
   input  wire logic [IDX_W-1:0]        int2_next,
   input  wire logic [3:0][3:0]         dsig_func,
   // Probe pin and feedback
   input  wire logic                    probe_input,
   input  wire logic signed [POS_W-1:0] actual_pos,
   input  wire logic signed [POS_W-1:0] actual_speed,
   input  wire logic                    pos_in_window,
   input  wire logic                    drive_stopped,
   // Drive commands
   output logic                         move_go_ff,
   output logic signed [POS_W-1:0]      target_ff,
   output logic                         move_fwd_ff,
   output logic signed [POS_W-1:0]      vel_cmd_ff,
   output logic                         vel_active_ff,
   output logic                         stop_req_ff,
   output logic                         emg_ramp_ff,
   output logic                         drive_off_ff,
   // Sequencer and status
   output logic                         seq_halt_ff,
   output logic                         next_req_ff,
   output logic [IDX_W-1:0]             next_idx_ff,
   output logic                         error_ff,
   output logic [15:0]                  err_code_ff,
   output logic                         target_reached_ff,
   output logic                         speed_reached_ff,
   output logic [3:0]                   dig_out_ff
);

   if (POS_W < 8 || IDX_W < 6 || IDX_W > 7)
      $error("pvm_motion_block: POS_W or IDX_W out of range");

   function automatic logic signed [POS_W:0] pvm_dist(
      input logic signed [POS_W-1:0] a,
      input logic signed [POS_W-1:0] b,
      input logic                    fwd);
      logic signed [POS_W:0] d;
      d = {a[POS_W-1], a} - {b[POS_W-1], b};
      return fwd ? d : -d;
   endfunction

   pvm_probe_if #(.POS_W(POS_W)) p ();

   pvm_probe_capture u_cap (
      .clk         (clk),
      .resetn      (resetn),
      .probe_input (probe_input),
      .p           (p.cap)
   );

   pvm_pkg::pvm_state_type state_ff, nxt_state;
   logic signed [POS_W-1:0] win_start_ff, nxt_win_start;
   logic signed [POS_W-1:0] last_tgt_ff, nxt_last_tgt;
   logic signed [POS_W-1:0] nxt_target, nxt_vel_cmd, probe_tgt;
   logic [31:0]             dly_cnt_ff, nxt_dly_cnt;
   logic rise_sel_ff, nxt_rise_sel, blk_run_ff, nxt_blk_run;
   logic nxt_move_go, nxt_move_fwd, nxt_vel_active, nxt_stop_req;
   logic nxt_emg_ramp, nxt_drive_off, nxt_seq_halt, nxt_next_req;
   logic [IDX_W-1:0] nxt_next_idx;
   logic nxt_error, nxt_tgt_reached, nxt_spd_reached, miss;
   logic [15:0] nxt_err_code;
   logic [3:0]  nxt_dig_out;
   logic signed [POS_W:0] travelled, spd_err;

   assign p.rise_sel = rise_sel_ff;
   assign p.act_pos  = actual_pos;
   assign probe_tgt  = p.cap_pos + blk_distance;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_state = state_ff;     nxt_win_start = win_start_ff;
      nxt_last_tgt = last_tgt_ff; nxt_target = target_ff;
      nxt_vel_cmd = vel_cmd_ff; nxt_dly_cnt = dly_cnt_ff;
      nxt_rise_sel = rise_sel_ff; nxt_blk_run = blk_run_ff;
      nxt_move_go = 1'b0;       nxt_move_fwd = move_fwd_ff;
      nxt_vel_active = 1'b0;    nxt_stop_req = stop_req_ff;
      nxt_emg_ramp = emg_ramp_ff; nxt_drive_off = drive_off_ff;
      nxt_seq_halt = seq_halt_ff; nxt_next_req = 1'b0;
      nxt_next_idx = next_idx_ff; nxt_error = error_ff;
      nxt_err_code = err_code_ff;
      travelled = pvm_dist(actual_pos, win_start_ff, move_fwd_ff);
      miss = state_ff == pvm_pkg::st_armed && !p.edge_hit && window_len != '0
             && travelled > $signed({2'b00, window_len});
      if (state_ff == pvm_pkg::st_move)
         nxt_move_fwd = target_ff > actual_pos;
      unique case (state_ff)
         pvm_pkg::st_armed:
         begin
            if (p.edge_hit)
            begin
               nxt_target   = probe_tgt;
               nxt_last_tgt = probe_tgt;
               nxt_vel_cmd  = '0;
               nxt_move_go  = 1'b1;
               nxt_state    = pvm_pkg::st_move;
            end
            else if (miss)
            begin
               nxt_vel_cmd = '0;
               if (miss_action == `PVM_ACT_EMSTOP || miss_action == `PVM_ACT_STOP)
               begin
                  nxt_emg_ramp = miss_action == `PVM_ACT_EMSTOP;
                  nxt_stop_req = 1'b1;
                  nxt_state    = pvm_pkg::st_stop;
               end
               else if (miss_action == `PVM_ACT_OFF)
               begin
                  nxt_drive_off = 1'b1;
                  nxt_error     = 1'b1;
                  nxt_err_code  = `PVM_ERR_NO_PROBE;
                  nxt_state     = pvm_pkg::st_err;
               end
               else if (miss_action == `PVM_ACT_HALT || miss_action[6]
                        || miss_action > `PVM_ACT_BLK_MAX)
               begin
                  nxt_seq_halt = 1'b1;
                  nxt_stop_req = 1'b1;
                  nxt_state    = pvm_pkg::st_halt;
               end
               else
               begin
                  nxt_next_req = 1'b1;
                  nxt_next_idx = miss_action[IDX_W-1:0];
                  nxt_state    = pvm_pkg::st_idle;
               end
            end
         end
         pvm_pkg::st_stop:
            if (drive_stopped)
            begin
               nxt_error    = 1'b1;
               nxt_err_code = `PVM_ERR_NO_PROBE;
               nxt_state    = pvm_pkg::st_err;
            end
         pvm_pkg::st_vel:
            nxt_vel_active = 1'b1;
         pvm_pkg::st_err:
            if (err_ack)
            begin
               nxt_error     = 1'b0;
               nxt_err_code  = `PVM_ERR_NONE;
               nxt_drive_off = 1'b0;
               nxt_stop_req  = 1'b0;
               nxt_state     = pvm_pkg::st_idle;
            end
         pvm_pkg::st_idle, pvm_pkg::st_move, pvm_pkg::st_halt:
            nxt_state = state_ff;
      endcase
      if (blk_run_ff && (state_ff == pvm_pkg::st_move || state_ff == pvm_pkg::st_vel
                         || state_ff == pvm_pkg::st_armed) && !miss && !p.edge_hit)
      begin
         nxt_dly_cnt = dly_cnt_ff + `PVM_CNT_ONE;
         nxt_next_req = 1'b1;
         if (int_event1)        nxt_next_idx = int1_next;
         else if (int_event2)   nxt_next_idx = int2_next;
         else if (event1)       nxt_next_idx = event1_next;
         else if (event2)       nxt_next_idx = event2_next;
         else if (delay_cycles != `PVM_CNT_RST && nxt_dly_cnt == delay_cycles)
            nxt_next_idx = delay_next;
         else
            nxt_next_req = 1'b0;
         if (nxt_next_req)
            nxt_blk_run = 1'b0;
      end
      if (blk_start && state_ff != pvm_pkg::st_err)
      begin
         nxt_dly_cnt  = `PVM_CNT_RST;
         nxt_blk_run  = 1'b1;
         nxt_next_req = 1'b0;
         nxt_seq_halt = 1'b0;
         nxt_stop_req = 1'b0;
         nxt_emg_ramp = 1'b0;
         nxt_move_go  = 1'b0;
         nxt_vel_cmd  = '0;
         nxt_state    = pvm_pkg::st_idle;
         if (blk_mode == `PVM_MODE_TP_RISE || blk_mode == `PVM_MODE_TP_FALL)
         begin
            nxt_rise_sel = blk_mode == `PVM_MODE_TP_RISE;
            nxt_win_start = jog_done ? actual_pos : last_tgt_ff;
            nxt_move_fwd  = !blk_speed[POS_W-1];
            nxt_vel_cmd   = blk_speed;
            nxt_state     = pvm_pkg::st_armed;
         end
         else if (blk_mode == `PVM_MODE_VEL)
         begin
            nxt_vel_cmd    = blk_speed;
            nxt_vel_active = 1'b1;
            nxt_state      = pvm_pkg::st_vel;
         end
      end
      nxt_last_tgt = jog_done && nxt_state == pvm_pkg::st_idle ? actual_pos : nxt_last_tgt;
      nxt_tgt_reached = (target_reached_ff || state_ff == pvm_pkg::st_move)
                        && pos_in_window && !blk_start;
      spd_err = pvm_dist(actual_speed, vel_cmd_ff, actual_speed >= vel_cmd_ff);
      nxt_spd_reached = vel_active_ff && spd_err <= (POS_W + 1)'(SPD_TOL);
      for (int i = 0; i < 4; i++)
         nxt_dig_out[i] = (dsig_func[i] == `PVM_FUNC_REF_ON && nxt_spd_reached)
                          || (dsig_func[i] == `PVM_FUNC_TGT && nxt_tgt_reached);
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_ff <= pvm_pkg::st_idle;    win_start_ff <= `PVM_POS_RST;
         last_tgt_ff <= `PVM_POS_RST;     target_ff <= `PVM_POS_RST;
         vel_cmd_ff <= `PVM_POS_RST;      dly_cnt_ff <= `PVM_CNT_RST;
         rise_sel_ff <= 1'b1;             blk_run_ff <= 1'b0;
         move_go_ff <= 1'b0;              move_fwd_ff <= 1'b1;
         vel_active_ff <= 1'b0;           stop_req_ff <= 1'b0;
         emg_ramp_ff <= 1'b0;             drive_off_ff <= 1'b0;
         seq_halt_ff <= 1'b0;             next_req_ff <= 1'b0;
         next_idx_ff <= `PVM_IDX_RST;     error_ff <= 1'b0;
         err_code_ff <= `PVM_ERR_NONE;    target_reached_ff <= 1'b0;
         speed_reached_ff <= 1'b0;        dig_out_ff <= 4'h0;
      end
      else
      begin
         state_ff <= nxt_state;           win_start_ff <= nxt_win_start;
         last_tgt_ff <= nxt_last_tgt;     target_ff <= nxt_target;
         vel_cmd_ff <= nxt_vel_cmd;       dly_cnt_ff <= nxt_dly_cnt;
         rise_sel_ff <= nxt_rise_sel;     blk_run_ff <= nxt_blk_run;
         move_go_ff <= nxt_move_go;       move_fwd_ff <= nxt_move_fwd;
         vel_active_ff <= nxt_vel_active; stop_req_ff <= nxt_stop_req;
         emg_ramp_ff <= nxt_emg_ramp;     drive_off_ff <= nxt_drive_off;
         seq_halt_ff <= nxt_seq_halt;     next_req_ff <= nxt_next_req;
         next_idx_ff <= nxt_next_idx;     error_ff <= nxt_error;
         err_code_ff <= nxt_err_code;     target_reached_ff <= nxt_tgt_reached;
         speed_reached_ff <= nxt_spd_reached;
         dig_out_ff <= nxt_dig_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_arm_rise;
      blk_start && !error_ff && blk_mode == `PVM_MODE_TP_RISE |=> rise_sel_ff;
   endproperty
   a_arm_rise: assert property (p_arm_rise) else $error("rising edge not armed");

   property p_probe_move;
      state_ff == pvm_pkg::st_armed && p.edge_hit && !blk_start
      |=> move_go_ff && target_ff == $past(probe_tgt) ##1 !move_go_ff;
   endproperty
   a_probe_move: assert property (p_probe_move) else $error("probe move wrong");

   property p_no_window;
      state_ff == pvm_pkg::st_armed && window_len == '0 && !p.edge_hit && !blk_start
      |=> state_ff == pvm_pkg::st_armed;
   endproperty
   a_no_window: assert property (p_no_window) else $error("window not disabled");

   property p_emstop;
      miss && !blk_start && miss_action == `PVM_ACT_EMSTOP |=> emg_ramp_ff && stop_req_ff;
   endproperty
   a_emstop: assert property (p_emstop) else $error("no emergency stop");

   property p_stop_err;
      state_ff == pvm_pkg::st_stop && drive_stopped && !blk_start
      |=> error_ff && err_code_ff == `PVM_ERR_NO_PROBE;
   endproperty
   a_stop_err: assert property (p_stop_err) else $error("error not raised");

   property p_coast;
      miss && !blk_start && miss_action == `PVM_ACT_OFF |=> drive_off_ff && error_ff;
   endproperty
   a_coast: assert property (p_coast) else $error("output not off");

   property p_halt;
      miss && !blk_start && miss_action == `PVM_ACT_HALT |=> seq_halt_ff && !error_ff;
   endproperty
   a_halt: assert property (p_halt) else $error("halt not taken");

   property p_jump;
      miss && !blk_start && !miss_action[6] && miss_action != '0
      && miss_action <= `PVM_ACT_BLK_MAX
      |=> next_req_ff && next_idx_ff == $past(miss_action[IDX_W-1:0]);
   endproperty
   a_jump: assert property (p_jump) else $error("block jump wrong");

   property p_velocity;
      blk_start && !error_ff && blk_mode == `PVM_MODE_VEL
      |=> vel_cmd_ff == $past(blk_speed) && vel_active_ff;
   endproperty
   a_velocity: assert property (p_velocity) else $error("velocity block wrong");

   property p_tgt_clear;
      !pos_in_window || blk_start |=> !target_reached_ff;
   endproperty
   a_tgt_clear: assert property (p_tgt_clear) else $error("target flag stuck");

   c_probe_hit: cover property (state_ff == pvm_pkg::st_armed && p.edge_hit);
   c_miss:      cover property (miss);
   c_spd:       cover property (vel_active_ff ##1 speed_reached_ff);

endmodule

// File: core/pvm_params.svh
// Constants for the probe and velocity motion block.
// Assumes inclusion by bare name from every core file that needs it.
`ifndef PVM_PARAMS_SVH
`define PVM_PARAMS_SVH

// Motion mode codes
`define PVM_MODE_TP_RISE   5'h02
`define PVM_MODE_TP_FALL   5'h03
`define PVM_MODE_VEL       5'h04

// Probe-miss action codes, seven bit two's complement
`define PVM_ACT_EMSTOP     7'h7d
`define PVM_ACT_STOP       7'h7e
`define PVM_ACT_OFF        7'h7f
`define PVM_ACT_HALT       7'h00
`define PVM_ACT_BLK_MAX    7'h20

// Error code for a missing probe edge
`define PVM_ERR_NO_PROBE   16'h1573
`define PVM_ERR_NONE       16'h0000

// Digital status output functions
`define PVM_FUNC_OFF       4'h0
`define PVM_FUNC_REF_ON    4'h1
`define PVM_FUNC_TGT       4'h2

// Reset values
`define PVM_POS_RST        32'h0000_0000
`define PVM_IDX_RST        6'h00
`define PVM_CNT_RST        32'h0000_0000
`define PVM_CNT_ONE        32'h0000_0001

`endif

// File: core/pvm_pkg.sv
// Types shared by the probe and velocity motion block.
// Assumes nothing beyond a SystemVerilog compiler.
package pvm_pkg;

   typedef enum logic [2:0] {
      st_idle,
      st_armed,
      st_move,
      st_vel,
      st_stop,
      st_halt,
      st_err
   } pvm_state_type;

endpackage

// File: core/pvm_probe_if.sv
// Link between the motion core and the probe capture unit.
// Assumes both ends run on the same clock.
interface pvm_probe_if #(parameter int POS_W = 32);
   logic                    rise_sel;
   logic signed [POS_W-1:0] act_pos;
   logic                    edge_hit;
   logic signed [POS_W-1:0] cap_pos;

   modport cap  (input rise_sel, act_pos, output edge_hit, cap_pos);
   modport core (output rise_sel, act_pos, input edge_hit, cap_pos);
endinterface

// File: core/pvm_probe_capture.sv
// Probe pin synchroniser, edge detector and position latch.
// Assumes the probe pin is asynchronous to clk.
`include "pvm_params.svh"

module pvm_probe_capture (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Dedicated probe pin
   input  wire logic probe_input,
   // Core side
   pvm_probe_if.cap  p
);

   logic sync1_ff;
   logic sync2_ff;
   logic prev_ff;
   logic hit_ff;
   logic signed [$bits(p.cap_pos)-1:0] cap_ff;
   logic nxt_sync1;
   logic nxt_sync2;
   logic nxt_prev;
   logic nxt_hit;
   logic signed [$bits(p.cap_pos)-1:0] nxt_cap;
   logic edge_seen;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_sync1 = probe_input;
      nxt_sync2 = sync1_ff;
      nxt_prev  = sync2_ff;
      edge_seen = p.rise_sel ? (sync2_ff & ~prev_ff) : (~sync2_ff & prev_ff);
      nxt_hit   = edge_seen;
      nxt_cap   = edge_seen ? p.act_pos : cap_ff;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff  <= 1'b0;
         hit_ff   <= 1'b0;
         cap_ff   <= `PVM_POS_RST;
      end
      else
      begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
         prev_ff  <= nxt_prev;
         hit_ff   <= nxt_hit;
         cap_ff   <= nxt_cap;
      end
   end

   assign p.edge_hit = hit_ff;
   assign p.cap_pos  = cap_ff;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_edge_sel;
      p.rise_sel && sync2_ff && !prev_ff |=> p.edge_hit;
   endproperty
   a_edge_sel: assert property (p_edge_sel) else $error("rising edge missed");

   property p_cap_pos;
      p.edge_hit |-> p.cap_pos == $past(p.act_pos);
   endproperty
   a_cap_pos: assert property (p_cap_pos) else $error("position not latched");

   c_fall: cover property (!p.rise_sel && p.edge_hit);

endmodule

// File: sim/pvm_feedback.sv
// Feedback model: probe switch and an encoder that follows the speed command.
// Assumes the bench sets the switch level and that everything shares clk.
module pvm_feedback (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               resetn,
   // Commands
   input  wire logic signed [31:0] vel_cmd,
   input  wire logic               halt_cmd,
   input  wire logic               switch_lvl,
   // Feedback
   output logic                    probe_input,
   output logic signed [31:0]      actual_pos,
   output logic signed [31:0]      actual_speed,
   output logic                    pos_in_window,
   output logic                    drive_stopped
);
   timeunit 1ns;
   timeprecision 1ps;

   assign probe_input   = switch_lvl;
   assign pos_in_window = (vel_cmd == 32'sh0);

   // Standstill one cycle after a stop, so the core must wait for it
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         actual_pos    <= 32'sh0000_0100;
         actual_speed  <= 32'sh0;
         drive_stopped <= 1'b0;
      end
      else
      begin
         actual_pos    <= halt_cmd ? actual_pos : actual_pos + vel_cmd;
         actual_speed  <= halt_cmd ? 32'sh0 : vel_cmd;
         drive_stopped <= halt_cmd;
      end
   end
endmodule

// File: sim/pvm_motion_block_tb.sv
// Self-checking bench for the probe and velocity motion block.
// Assumes the core files and the feedback model are compiled first.
`include "pvm_params.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end

module pvm_motion_block_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0, resetn, blk_start, jog_done, err_ack, probe_lvl;
   logic event1, event2, int_event1, int_event2;
   logic [4:0] blk_mode;
   logic signed [31:0] blk_distance, blk_speed, actual_pos, actual_speed, target_ff, vel_cmd_ff;
   logic [30:0] window_len;
   logic [6:0] miss_action;
   logic [31:0] delay_cycles;
   logic [5:0] delay_next, event1_next, event2_next, int1_next, int2_next, next_idx_ff;
   logic [3:0][3:0] dsig_func;
   logic probe_input, pos_in_window, drive_stopped, move_go_ff, move_fwd_ff, vel_active_ff;
   logic stop_req_ff, emg_ramp_ff, drive_off_ff, seq_halt_ff, next_req_ff, error_ff;
   logic target_reached_ff, speed_reached_ff;
   logic [15:0] err_code_ff;
   logic [3:0] dig_out_ff;
   logic [6:0] acts [5] = '{`PVM_ACT_EMSTOP, `PVM_ACT_STOP, `PVM_ACT_OFF, `PVM_ACT_HALT, 7'h05};
   int err_total, n_compared;

   pvm_motion_block dut (.clk, .resetn, .blk_start, .blk_mode, .blk_distance, .blk_speed,
      .window_len, .miss_action, .jog_done, .err_ack, .delay_cycles, .delay_next, .event1,
      .event1_next, .event2, .event2_next, .int_event1, .int1_next, .int_event2, .int2_next,
      .dsig_func, .probe_input, .actual_pos, .actual_speed, .pos_in_window, .drive_stopped,
      .move_go_ff, .target_ff, .move_fwd_ff, .vel_cmd_ff, .vel_active_ff, .stop_req_ff,
      .emg_ramp_ff, .drive_off_ff, .seq_halt_ff, .next_req_ff, .next_idx_ff, .error_ff,
      .err_code_ff, .target_reached_ff, .speed_reached_ff, .dig_out_ff);

   pvm_feedback fb (.clk, .resetn, .vel_cmd(vel_cmd_ff), .halt_cmd(stop_req_ff | drive_off_ff),
      .switch_lvl(probe_lvl), .probe_input, .actual_pos, .actual_speed, .pos_in_window,
      .drive_stopped);

   always #2.5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////////////
   task start(input logic [4:0] m, input logic signed [31:0] d, s, input logic [30:0] w,
              input logic [6:0] a);
      @(posedge clk);
      {blk_mode, blk_distance, blk_speed, window_len, miss_action} <= {m, d, s, w, a};
      blk_start <= 1'b1;
      @(posedge clk);
      blk_start <= 1'b0;
   endtask

   // Zero search speed keeps the position still, so the latched value is known
   task t_probe(input logic [4:0] m);
      logic signed [31:0] p;
      @(posedge clk);
      probe_lvl <= (m == `PVM_MODE_TP_FALL);
      repeat (4) @(posedge clk);
      start(m, 32'sh0000_0123, 32'sh0, 31'h0, `PVM_ACT_HALT);
      @(negedge clk);
      p = actual_pos;
      @(posedge clk);
      probe_lvl <= ~probe_lvl;
      repeat (10) begin @(negedge clk); if (move_go_ff) break; end
      `CHK("move_go", 1'b1, move_go_ff)
      @(negedge clk);
      `CHK("target", p + 32'sh123, target_ff)
      repeat (2) @(negedge clk);
      `CHK("tgt_reached", 1'b1, target_reached_ff)
      start(5'h00, 32'sh0, 32'sh0, 31'h0, `PVM_ACT_HALT);
      repeat (2) @(negedge clk);
      `CHK("tgt_cleared", 1'b0, target_reached_ff)
   endtask

   // Search at 4 units a cycle past a 20 unit window with no edge; negative lat skips timing
   task t_miss(input logic [6:0] a, input logic [30:0] w, input int lat);
      logic on;
      logic stp;
      int n;
      on = (w != 31'h0);
      stp = on && a inside {`PVM_ACT_EMSTOP, `PVM_ACT_STOP, `PVM_ACT_OFF};
      start(`PVM_MODE_TP_RISE, 32'sh10, 32'sh4, w, a);
      for (n = 0; n < 100; n++)
      begin
         @(negedge clk);
         if (error_ff || seq_halt_ff || next_req_ff) break;
      end
      if (lat >= 0) `CHK("miss_lat", lat, n)
      `CHK("error", stp, error_ff)
      `CHK("err_code", stp ? `PVM_ERR_NO_PROBE : `PVM_ERR_NONE, err_code_ff)
      `CHK("stop_req", on && a inside {7'h7d, 7'h7e, 7'h00}, stop_req_ff)
      `CHK("emg_ramp", on && a == `PVM_ACT_EMSTOP, emg_ramp_ff)
      `CHK("drive_off", on && a == `PVM_ACT_OFF, drive_off_ff)
      `CHK("seq_halt", on && a == `PVM_ACT_HALT, seq_halt_ff)
      `CHK("next_req", on && a == 7'h05, next_req_ff)
      if (next_req_ff === 1'b1) `CHK("next_idx", 6'h05, next_idx_ff)
      @(posedge clk);
      err_ack <= 1'b1;
      @(posedge clk);
      err_ack <= 1'b0;
   endtask

   // Sources 0..3 are the two interrupt events then the two events; 4 is the delay
   task t_vel(input int k);
      int n;
      @(posedge clk);
      delay_cycles <= (k == 4) ? 32'hc : 32'h0;
      start(`PVM_MODE_VEL, 32'sh7fff, 32'sh20, 31'h0, `PVM_ACT_HALT);
      repeat (8) @(negedge clk);
      `CHK("vel_cmd", 32'sh20, vel_cmd_ff)
      `CHK("dig_out", 4'h9, dig_out_ff)
      `CHK("spd_reached", 1'b1, speed_reached_ff)
      @(posedge clk);
      {event2, event1, int_event2, int_event1} <= 4'h1 << k;
      for (n = 0; n < 12; n++)
      begin
         @(negedge clk);
         if (next_req_ff) break;
      end
      `CHK("next_lat", (k == 4) ? 4 : 1, n)
      `CHK("next_idx", (k == 4) ? 6'h09 : 6'h0b + 6'(k), next_idx_ff)
      `CHK("vel_active", 1'b1, vel_active_ff)
      @(posedge clk);
      {event2, event1, int_event2, int_event1} <= 4'h0;
   endtask

   task wrap_up();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {resetn, blk_start, jog_done, err_ack, probe_lvl} = 5'h00;
      {event1, event2, int_event1, int_event2} = 4'h0;
      {blk_mode, blk_distance, blk_speed, window_len, miss_action} = '0;
      {delay_cycles, delay_next, int1_next, int2_next} = {32'h0, 6'h09, 6'h0b, 6'h0c};
      {event1_next, event2_next, dsig_func} = {6'h0d, 6'h0e, 16'h1021};
      err_total = 0;
      n_compared = 0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      t_probe(`PVM_MODE_TP_RISE);
      t_probe(`PVM_MODE_TP_FALL);
      foreach (acts[i]) t_miss(acts[i], 31'h14, (i == 0) ? 81 : -1);
      @(posedge clk);
      jog_done <= 1'b1;
      t_miss(`PVM_ACT_OFF, 31'h14, 7);
      jog_done <= 1'b0;
      t_miss(`PVM_ACT_EMSTOP, 31'h0, -1);
      for (int k = 0; k < 5; k++) t_vel(k);
      wrap_up();
   end

   // The tests need well under a thousand cycles
   initial
   begin
      #20us;
      err_total++;
      wrap_up();
   end
endmodule
